// ==== rtl/axc_pkg.sv ====
package axc_pkg;

   // ***********************************************************
   // timing of the serial bus clocks
   // ***********************************************************
   localparam int CLK_FREQ_HZ   = 250_000_000; // aclk, 4 ns period
   localparam int DCL_FREQ_HZ   = 1_536_000;   // double-rate clock
   localparam int FRAME_FREQ_HZ = 8_000;       // frame sync rate
   // half period of the generated double-rate clock, rounded down
   localparam int DCL_HALF_CYC  = CLK_FREQ_HZ / (2 * DCL_FREQ_HZ);
   localparam logic [7:0] DCL_HALF_LAST = 8'(DCL_HALF_CYC - 1);
   // double-rate clock periods in one frame
   localparam int FRAME_DCL     = DCL_FREQ_HZ / FRAME_FREQ_HZ;
   localparam logic [9:0] FRAME_LAST = 10'(FRAME_DCL - 1);
   // double-rate clock edge at which the stop/go bit is sampled
   localparam logic [9:0] SG_DCL_POS = 10'h0b5;

   // ***********************************************************
   // register map, byte addresses
   // ***********************************************************
   localparam int AXI_ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_DIR      = 8'h04;
   localparam logic [7:0] OFS_OUT      = 8'h08;
   localparam logic [7:0] OFS_OD       = 8'h0c;
   localparam logic [7:0] OFS_PIN      = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFS_STROBE   = 8'h1c;

   // control register fields
   localparam int CB_MASTER    = 0; // device sources clock and frame
   localparam int CB_IRQ_PP    = 1; // irq active high push-pull
   localparam int CB_MF_SEL    = 2; // multiframe_select
   localparam int CB_CLK_OUT   = 3; // clock_output_select
   localparam int CB_FB_CHOICE = 4; // sync_or_bitclk_choice, 1 = bit clock
   localparam int CB_SG_EN     = 5; // pin 7 carries stop/go bit
   localparam int CB_EDGE_A    = 6; // ext_irq_a edge (1) or level (0)
   localparam int CB_EDGE_B    = 7; // ext_irq_b edge (1) or level (0)
   localparam int CB_MULTIFRAME_BIT_TX   = 8; // multiframe bit to send

   // values after reset
   localparam logic [8:0]  CTRL_RST   = 9'h000;
   localparam logic [7:0]  DIR_RST    = 8'h00;
   localparam logic [7:0]  OUT_RST    = 8'h00;
   localparam logic [7:0]  OD_RST     = 8'hff;
   localparam logic [1:0]  MASK_RST   = 2'h3;
   localparam logic [15:0] STROBE_RST = 16'h0000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {MODE_TE, MODE_LTT, MODE_LTS} axc_mode_e;

endpackage : axc_pkg

// ==== rtl/axc_aux_port.sv ====
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module axc_aux_port
   import axc_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output      logic                  s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output      logic                  s_axi_wready,
   output      logic [1:0]            s_axi_bresp,
   output      logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output      logic                  s_axi_arready,
   output      logic [31:0]           s_axi_rdata,
   output      logic [1:0]            s_axi_rresp,
   output      logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  mode_sel0,
   input  wire logic                  mode_sel1,
   input  wire logic [7:0]            aux_pin_in,
   output      logic [7:0]            aux_pin_out,
   output      logic [7:0]            aux_pin_oe_n,
   output      logic [1:0]            aux_pullup_en,
   output      logic [2:0]            channel_select,
   input  wire logic                  double_rate_clock_in,
   output      logic                  double_rate_clock_out,
   output      logic                  double_rate_clock_oe_n,
   input  wire logic                  frame_sync_in,
   output      logic                  frame_sync_out,
   output      logic                  frame_sync_oe_n,
   input  wire logic                  downstream_line,
   output      logic                  bit_clock_out,
   output      logic                  slot_strobe_one,
   output      logic                  slot_strobe_two,
   output      logic                  irq_out,
   output      logic                  irq_oe_n
);

   // ***********************************************************
   // helpers
   // ***********************************************************
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction : lane_merge

   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         OFS_CTRL, OFS_DIR, OFS_OUT, OFS_OD, OFS_PIN,
         OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_STROBE: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : is_mapped

   // strobe config byte: [4:0] slot, [5] slot enable, [6] d-channel enable
   function automatic logic strobe_hit(input logic [7:0] cfg,
                                       input logic [5:0] slot,
                                       input logic       dch);
      return (cfg[5] && slot == {1'b0, cfg[4:0]}) || (cfg[6] && dch);
   endfunction : strobe_hit

   // ***********************************************************
   // declarations
   // ***********************************************************
   logic [7:0]  aux_s1_r, aux_s2_r, aux_s3_r;
   logic [1:0]  mode_s1_r, mode_s2_r;
   logic        dcl_s1_r, dcl_s2_r, fsc_s1_r, fsc_s2_r, fsc_s3_r;
   logic        dd_s1_r, dd_s2_r;
   axc_mode_e   mode_r;
   logic [1:0]  mode_code;
   logic [8:0]  ctrl_r;
   logic [7:0]  dir_r, out_r, od_r;
   logic [1:0]  status_r, mask_r, stat_clr, irq_set, in_ok;
   logic [15:0] strobe_r;
   logic        aw_got_r, w_got_r, wr_en;
   logic [7:0]  waddr_r;
   logic [31:0] wdata_r, rd_word;
   logic [3:0]  wstrb_r;
   logic [7:0]  dcl_div_r;
   logic        dcl_int_r, dcl_prev_r, dcl_lvl, dcl_rise, fsc_lvl, fsc_rise;
   logic        master_eff, fsc_gen_r, bclk_r, stop_go_r, pending, dch_win;
   logic [9:0]  dcl_cnt_r;
   logic [5:0]  slot;
   logic [7:0]  drv_en, drv_val;

   // ***********************************************************
   // input synchronisers and mode straps
   // ***********************************************************
   // pins idle high, so the chain resets high and no false edge appears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aux_s1_r  <= 8'hff;
         aux_s2_r  <= 8'hff;
         aux_s3_r  <= 8'hff;
         mode_s1_r <= 2'h0;
         mode_s2_r <= 2'h0;
         dcl_s1_r  <= 1'b0;
         dcl_s2_r  <= 1'b0;
         fsc_s1_r  <= 1'b0;
         fsc_s2_r  <= 1'b0;
         fsc_s3_r  <= 1'b0;
         dd_s1_r   <= 1'b1;
         dd_s2_r   <= 1'b1;
      end else begin
         aux_s1_r  <= aux_pin_in;
         aux_s2_r  <= aux_s1_r;
         aux_s3_r  <= aux_s2_r;
         mode_s1_r <= {mode_sel1, mode_sel0};
         mode_s2_r <= mode_s1_r;
         dcl_s1_r  <= double_rate_clock_in;
         dcl_s2_r  <= dcl_s1_r;
         fsc_s1_r  <= frame_sync_in;
         fsc_s2_r  <= fsc_s1_r;
         fsc_s3_r  <= fsc_s2_r;
         dd_s1_r   <= downstream_line;
         dd_s2_r   <= dd_s1_r;
      end
   end

   // strap decode: sel0 low is terminal, else sel1 picks LT-S over LT-T
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= MODE_TE;
      end else if (!mode_s2_r[0]) begin
         mode_r <= MODE_TE;
      end else begin
         mode_r <= mode_s2_r[1] ? MODE_LTS : MODE_LTT;
      end
   end
   assign mode_code = mode_r;

   // ***********************************************************
   // axi4-lite slave
   // ***********************************************************
   // address and data are parked until both arrive, in either order
   assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_en         = aw_got_r && w_got_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         waddr_r  <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_got_r <= 1'b1;
         waddr_r  <= s_axi_awaddr;
      end else if (wr_en) begin
         aw_got_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_got_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end else if (wr_en) begin
         w_got_r <= 1'b0;
      end
   end

   // write response; unmapped addresses answer slverr and store nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_en) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= is_mapped(waddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read data mux
   always_comb begin
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         OFS_CTRL:     rd_word = {23'h0, ctrl_r};
         OFS_DIR:      rd_word = {24'h0, dir_r};
         OFS_OUT:      rd_word = {24'h0, out_r};
         OFS_OD:       rd_word = {24'h0, od_r};
         OFS_PIN:      rd_word = {21'h0, stop_go_r, mode_code, aux_s2_r};
         OFS_IRQ_STAT: rd_word = {30'h0, status_r};
         OFS_IRQ_MASK: rd_word = {30'h0, mask_r};
         OFS_STROBE:   rd_word = {16'h0, strobe_r};
         default:      rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ***********************************************************
   // configuration registers
   // ***********************************************************
   // all pins come up as inputs and both interrupts masked
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r   <= CTRL_RST;
         dir_r    <= DIR_RST;
         out_r    <= OUT_RST;
         od_r     <= OD_RST;
         mask_r   <= MASK_RST;
         strobe_r <= STROBE_RST;
      end else if (wr_en) begin
         case (waddr_r)
            OFS_CTRL: ctrl_r <= 9'(lane_merge(32'(ctrl_r), wdata_r, wstrb_r));
            OFS_DIR:  dir_r  <= 8'(lane_merge(32'(dir_r), wdata_r, wstrb_r));
            OFS_OUT:  out_r  <= 8'(lane_merge(32'(out_r), wdata_r, wstrb_r));
            OFS_OD:   od_r   <= 8'(lane_merge(32'(od_r), wdata_r, wstrb_r));
            OFS_IRQ_MASK:
               mask_r <= 2'(lane_merge(32'(mask_r), wdata_r, wstrb_r));
            OFS_STROBE:
               strobe_r <= 16'(lane_merge(32'(strobe_r), wdata_r, wstrb_r));
            default: ;
         endcase
      end
   end

   // ***********************************************************
   // double-rate clock, frame counter and bit clock
   // ***********************************************************
   // LT-S always takes clock and frame from outside
   assign master_eff = ctrl_r[CB_MASTER] && (mode_r != MODE_LTS);
   assign dcl_lvl    = master_eff ? dcl_int_r : dcl_s2_r;
   assign dcl_rise   = dcl_lvl && !dcl_prev_r;
   assign fsc_rise   = fsc_s2_r && !fsc_s3_r;
   assign fsc_lvl    = master_eff ? fsc_gen_r : fsc_s2_r;

   // free running 1.536 MHz generator; period rounds to 648 ns
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dcl_div_r <= 8'h00;
         dcl_int_r <= 1'b0;
      end else if (dcl_div_r == DCL_HALF_LAST) begin
         dcl_div_r <= 8'h00;
         dcl_int_r <= !dcl_int_r;
      end else begin
         dcl_div_r <= dcl_div_r + 8'h01;
      end
   end

   // frame position in double-rate clock periods
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dcl_prev_r <= 1'b0;
         dcl_cnt_r  <= 10'h000;
         fsc_gen_r  <= 1'b0;
      end else begin
         dcl_prev_r <= dcl_lvl;
         fsc_gen_r  <= master_eff && (dcl_cnt_r == 10'h000);
         if (!master_eff && fsc_rise) begin
            dcl_cnt_r <= 10'h000;
         end else if (dcl_rise) begin
            if (master_eff && dcl_cnt_r == FRAME_LAST) begin
               dcl_cnt_r <= 10'h000;
            end else begin
               dcl_cnt_r <= dcl_cnt_r + 10'h001;
            end
         end
      end
   end

   // halve whichever double-rate clock is in use
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bclk_r <= 1'b0;
      end else if (dcl_rise) begin
         bclk_r <= !bclk_r;
      end
   end
   // LT-T has no line timing here, so the local generator stands in
   assign bit_clock_out = (mode_r == MODE_LTT) ? dcl_int_r : bclk_r;

   assign double_rate_clock_out  = dcl_int_r;
   assign double_rate_clock_oe_n = !master_eff;
   assign frame_sync_out         = fsc_gen_r;
   assign frame_sync_oe_n        = !master_eff;

   // ***********************************************************
   // strobes, stop/go bit and channel select
   // ***********************************************************
   // 16 double-rate periods per slot; d-channel is bits 0-1 of slot 4*channel_select+3
   assign slot    = dcl_cnt_r[9:4];
   assign dch_win = (slot == {1'b0, channel_select, 2'b11}) &&
                    (dcl_cnt_r[3:2] == 2'b00);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slot_strobe_one <= 1'b0;
         slot_strobe_two <= 1'b0;
         stop_go_r       <= 1'b0;
         channel_select  <= 3'h0;
      end else begin
         slot_strobe_one <= strobe_hit(strobe_r[7:0], slot, dch_win);
         slot_strobe_two <= strobe_hit(strobe_r[15:8], slot, dch_win);
         channel_select  <= (mode_r == MODE_TE) ? 3'h0 : aux_s2_r[2:0];
         if (dcl_rise && dcl_cnt_r == SG_DCL_POS) begin
            stop_go_r <= dd_s2_r;
         end
      end
   end

   // ***********************************************************
   // pin multiplexing and drivers
   // ***********************************************************
   always_comb begin
      drv_en  = dir_r;
      drv_val = out_r;
      if (mode_r != MODE_TE) begin
         drv_en[2:0] = 3'h0;
      end
      if (ctrl_r[CB_MF_SEL]) begin
         drv_en[4]  = (mode_r == MODE_TE) || (mode_r == MODE_LTT);
         drv_val[4] = ctrl_r[CB_MULTIFRAME_BIT_TX];
      end
      if (ctrl_r[CB_CLK_OUT]) begin
         drv_en[5]  = 1'b1;
         drv_val[5] = ctrl_r[CB_FB_CHOICE] ? bit_clock_out : fsc_lvl;
      end
      if (ctrl_r[CB_SG_EN]) begin
         drv_en[7]  = 1'b1;
         drv_val[7] = stop_go_r;
      end
   end

   // open-drain pins only pull low; push-pull pins drive both levels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aux_pin_out  <= 8'h00;
         aux_pin_oe_n <= 8'hff;
      end else begin
         aux_pin_out  <= drv_val & ~od_r;
         aux_pin_oe_n <= ~(drv_en & (~od_r | ~drv_val));
      end
   end
   assign aux_pullup_en = od_r[7:6];

   // ***********************************************************
   // interrupts from pins 6 and 7
   // ***********************************************************
   // a falling edge or a low level, only while the pin is an input
   assign in_ok   = ~drv_en[7:6];
   assign irq_set = in_ok &
                    (({ctrl_r[CB_EDGE_B], ctrl_r[CB_EDGE_A]} &
                      aux_s3_r[7:6] & ~aux_s2_r[7:6]) |
                     (~{ctrl_r[CB_EDGE_B], ctrl_r[CB_EDGE_A]} &
                      ~aux_s2_r[7:6]));
   assign stat_clr = (wr_en && waddr_r == OFS_IRQ_STAT && wstrb_r[0]) ?
                     wdata_r[1:0] : 2'h0;
   assign pending  = |(status_r & ~mask_r);

   // set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= 2'h0;
      end else begin
         status_r <= (status_r & ~stat_clr) | irq_set;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_out  <= 1'b0;
         irq_oe_n <= 1'b1;
      end else begin
         irq_out  <= ctrl_r[CB_IRQ_PP] && pending;
         irq_oe_n <= !ctrl_r[CB_IRQ_PP] && !pending;
      end
   end

   // ***********************************************************
   // assertions
   // ***********************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence fall_a_s;
      $fell(aux_s2_r[6]) && ctrl_r[CB_EDGE_A] && !drv_en[6];
   endsequence
   sequence od_pending_s;
      pending && !ctrl_r[CB_IRQ_PP];
   endsequence
   sequence frame_end_s;
      master_eff && dcl_rise && dcl_cnt_r == FRAME_LAST;
   endsequence

   irq_od_drive_a: assert property (
      od_pending_s |=> !irq_oe_n && !irq_out)
      else $error("open-drain interrupt not pulled low");
   edge_irq_a: assert property (
      fall_a_s |=> status_r[0])
      else $error("falling edge on pin 6 not latched");
   reset_idle_a: assert property (
      !$past(aresetn) |-> aux_pin_oe_n == 8'hff && mask_r == 2'h3)
      else $error("pins or masks not idle after reset");
   low_pins_in_a: assert property (
      mode_r != MODE_TE |=> aux_pin_oe_n[2:0] == 3'h7)
      else $error("channel select pins driven outside terminal mode");
   bclk_half_a: assert property (
      $changed(bclk_r) |-> $past(dcl_rise))
      else $error("bit clock moved without a double-rate edge");
   dcl_rate_a: assert property (
      $changed(dcl_int_r) |-> $past(dcl_div_r) == DCL_HALF_LAST)
      else $error("double-rate clock half period wrong");
   frame_wrap_a: assert property (
      frame_end_s |=> dcl_cnt_r == 10'h000 ##1 frame_sync_out)
      else $error("frame did not restart with sync pulse");
   clk_out_pin_a: assert property (
      ctrl_r[CB_CLK_OUT] && ctrl_r[CB_FB_CHOICE] && !od_r[5]
      |=> !aux_pin_oe_n[5] && aux_pin_out[5] == $past(bit_clock_out))
      else $error("pin 5 not carrying bit clock");
   stop_go_pin_a: assert property (
      ctrl_r[CB_SG_EN] && !od_r[7]
      |=> !aux_pin_oe_n[7] && aux_pin_out[7] == $past(stop_go_r))
      else $error("pin 7 not carrying stop/go bit");
   multiframe_bit_out_a: assert property (
      ctrl_r[CB_MF_SEL] && mode_r == MODE_TE && !od_r[4]
      |=> !aux_pin_oe_n[4] && aux_pin_out[4] == $past(ctrl_r[CB_MULTIFRAME_BIT_TX]))
      else $error("pin 4 not carrying multiframe bit");
   strobe_slot_a: assert property (
      strobe_r[5] && slot == {1'b0, strobe_r[4:0]} |=> slot_strobe_one)
      else $error("strobe one missed its time slot");

endmodule : axc_aux_port

// ==== dv/axc_pin_model.sv ====
`timescale 1ns/1ns
// ***********************************************************
// far side of the pins: keypad drivers, pull-ups, floating pins
// ***********************************************************
module axc_pin_model (
   input  wire logic       aclk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   input  wire logic [1:0] pullup_en,
   input  wire logic [7:0] ext_val,
   input  wire logic [7:0] ext_en,
   output      logic [7:0] pin_in
);
   // a floating pin wanders, so a stale level can never pass a check
   logic toggle_r = 1'b0;
   always_ff @(posedge aclk) toggle_r <= ~toggle_r;
   // device drive first, then keypad, then the pull-up of pins 6 and 7
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (i >= 6 && pullup_en[i % 2]) pin_in[i] = 1'b1;
         else pin_in[i] = toggle_r;
      end
   end
endmodule : axc_pin_model

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
module tb_top
   import axc_pkg::*;
;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, mode_sel0, mode_sel1;
   logic [7:0] s_axi_awaddr, s_axi_araddr, aux_pin_in, aux_pin_out;
   logic [7:0] aux_pin_oe_n, ext_val, ext_en;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, aux_pullup_en;
   logic [2:0] channel_select;
   logic double_rate_clock_out, double_rate_clock_oe_n, frame_sync_out;
   logic frame_sync_oe_n, bit_clock_out, slot_strobe_one, slot_strobe_two;
   logic irq_out, irq_oe_n, ext_dcl;
   int n_errors = 0, n_compared = 0;
   axc_aux_port i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mode_sel0, .mode_sel1,
      .aux_pin_in, .aux_pin_out, .aux_pin_oe_n, .aux_pullup_en,
      .channel_select, .double_rate_clock_in(ext_dcl), .double_rate_clock_out,
      .double_rate_clock_oe_n, .frame_sync_in(1'b0), .frame_sync_out,
      .frame_sync_oe_n, .downstream_line(1'b1), .bit_clock_out,
      .slot_strobe_one, .slot_strobe_two, .irq_out, .irq_oe_n);
   axc_pin_model i_pins (.aclk, .pin_out(aux_pin_out),
      .pin_oe_n(aux_pin_oe_n), .pullup_en(aux_pullup_en), .ext_val,
      .ext_en, .pin_in(aux_pin_in));
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task automatic give_verdict;
      $display("compared %0d, wrong %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one write, each channel released at the edge that takes it
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      for (int i = 0; i < 100; i++) begin
         @(negedge aclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid & s_axi_bready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) begin
            s_axi_bready <= 1'b0;
            chk({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
            // one idle edge, so the next call never re-raises bready here
            @(posedge aclk);
            return;
         end
      end
      n_errors++;
      give_verdict();
   endtask : axw
   task automatic axr(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] resp);
      logic ta, tr;
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      for (int i = 0; i < 100; i++) begin
         @(negedge aclk);
         ta = s_axi_arvalid & s_axi_arready;
         tr = s_axi_rvalid;
         rd = s_axi_rdata & exp[31:0];
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) begin
            s_axi_rready <= 1'b0;
            chk({30'h0, s_axi_rresp}, {30'h0, resp});
            @(posedge aclk);
            return;
         end
      end
      n_errors++;
      give_verdict();
   endtask : axr
   // ***********************************************************
   // scenarios
   // ***********************************************************
   task automatic t_gpio;
      axw(OFS_DIR, 32'h0f); axw(OFS_OD, 32'h00); axw(OFS_OUT, 32'h0a);
      repeat (3) @(posedge aclk);
      chk(aux_pin_oe_n, 8'hf0);
      chk(aux_pullup_en, 2'h0);
      axr(OFS_PIN, 32'hf, RESP_OKAY); chk(rd, 32'ha);
      axw(OFS_OD, 32'hff); axw(OFS_DIR, 32'h00);
      $display("gpio test done");
   endtask : t_gpio
   task automatic t_irq;
      axw(OFS_CTRL, 32'h40); axw(OFS_IRQ_MASK, 32'h2);
      ext_val[6] <= 1'b0; repeat (6) @(posedge aclk);
      chk({irq_out, irq_oe_n}, 2'b00);
      axw(OFS_IRQ_STAT, 32'h1); repeat (3) @(posedge aclk);
      chk(irq_oe_n, 1'b1);
      axw(OFS_CTRL, 32'h02); repeat (6) @(posedge aclk);
      chk({irq_out, irq_oe_n}, 2'b10);
      axw(OFS_IRQ_STAT, 32'h1); axr(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
      chk(rd, 32'h1);
      axw(OFS_IRQ_MASK, 32'h3); repeat (3) @(posedge aclk);
      chk(irq_out, 1'b0);
      ext_val[6] <= 1'b1;
      axr(8'h40, 32'hffffffff, RESP_SLVERR); chk(rd, 32'h0);
      $display("irq test done");
   endtask : t_irq
   // master clocks over one whole frame, pins 4, 5 and 7 on alternate use
   task automatic t_clk;
      logic [5:0] cur, prv;
      int n [6];
      int k;
      axw(OFS_OD, 32'h4f); axw(OFS_STROBE, 32'h2225);
      axw(OFS_CTRL, 32'h13d);
      // the first frame after turning master on is cut short, skip it
      k = 0;
      while (frame_sync_out && k < 40000) begin
         @(posedge aclk);
         k++;
      end
      while (!frame_sync_out && k < 40000) begin
         @(posedge aclk);
         k++;
      end
      if (k == 40000) begin
         n_errors++;
         give_verdict();
      end
      n = '{default: 0};
      prv = {slot_strobe_two, slot_strobe_one, aux_pin_out[5],
             bit_clock_out, double_rate_clock_out, frame_sync_out};
      repeat (FRAME_DCL * 2 * DCL_HALF_CYC + DCL_HALF_CYC) begin
         @(posedge aclk);
         cur = {slot_strobe_two, slot_strobe_one, aux_pin_out[5],
                bit_clock_out, double_rate_clock_out, frame_sync_out};
         for (int b = 0; b < 6; b++) begin
            if (cur[b] && !prv[b]) n[b]++;
         end
         prv = cur;
      end
      chk(n[0], 32'h1);
      chk(n[1], FRAME_DCL);
      chk(n[2], FRAME_DCL / 2);
      chk(n[3], FRAME_DCL / 2);
      chk(n[4], 32'h1);
      chk(n[5], 32'h1);
      chk({double_rate_clock_oe_n, frame_sync_oe_n}, 2'b00);
      chk({aux_pin_out[7], aux_pin_out[4]}, 2'b11);
      $display("clock test done");
   endtask : t_clk
   task automatic t_chan;
      logic prv;
      int n = 0;
      axw(OFS_DIR, 32'h07);
      mode_sel0 <= 1'b1; mode_sel1 <= 1'b1; ext_val[2:0] <= 3'h5;
      ext_en[2:0] <= 3'h7;
      // outside double-rate clock, 8 aclk a period, bit clock is half
      for (int i = 0; i < 80; i++) begin
         @(posedge aclk);
         ext_dcl <= i[2];
         if (i >= 16 && bit_clock_out && !prv) n++;
         prv = bit_clock_out;
      end
      chk(n, 32'h4);
      chk(channel_select, 3'h5);
      chk(aux_pin_oe_n[2:0], 3'h7);
      $display("channel test done");
   endtask : t_chan
   initial begin
      aresetn = 1'b0; mode_sel0 = 1'b0; mode_sel1 = 1'b0;
      s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0;
      ext_val = 8'hc0; ext_en = 8'h40; ext_dcl = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk({aux_pin_oe_n, aux_pullup_en, irq_oe_n}, 11'h7ff);
      axr(OFS_IRQ_MASK, 32'h3, RESP_OKAY); chk(rd, 32'h3);
      t_gpio();
      t_irq();
      t_clk();
      t_chan();
      give_verdict();
   end
endmodule : tb_top
